// File: adc_analog_model.sv
module adc_analog_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] inputChannelSelect,
   input wire logic tempSelected,
   input wire logic tempSenseEnable,
   input wire logic tempRangeHigh,
   input wire logic sampleStrobe,
   output logic sampleBit
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] bitCnt;
   logic lastBit;
   logic [9:0] level;
   // ==========================================
   // level on the selected channel
   always_comb begin
      if (!tempSelected) level = {inputChannelSelect, ~inputChannelSelect};
      else if (!tempSenseEnable) level = 10'h000;
      else if (tempRangeHigh) level = 10'h2c5;
      else level = 10'h1a3;
   end
   // ==========================================
   // comparator decisions, msb first; junk between strobes
   assign sampleBit = sampleStrobe ? level[4'h9 - bitCnt] : ~lastBit;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bitCnt <= 4'h0;
         lastBit <= 1'b0;
      end else begin
         lastBit <= sampleBit;
         if (sampleStrobe) bitCnt <= (bitCnt == 4'h9) ? 4'h0 : bitCnt + 4'h1;
      end
   end
endmodule

// File: adc_clock_result_control.sv
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
module adc_clock_result_control (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sampleBit,
   output logic [4:0] inputChannelSelect,
   output logic tempSelected,
   output logic tempSenseEnable,
   output logic tempRangeHigh,
   output logic sampleStrobe,
   output logic convIrq
);
   // ==========================================
   // bus slave
   logic wrPend_reg, wrPend_next;
   logic [7:0] wrAddr_reg, wrAddr_next;
   logic [7:0] ctrlA_reg, ctrlA_next;
   logic [7:0] ctrlB_reg, ctrlB_next;
   logic [7:0] trig_reg, trig_next;
   logic [7:0] resHi_reg, resHi_next;
   logic [7:0] resLo_reg, resLo_next;
   logic [7:0] vref_reg, vref_next;
   logic irqStat_reg, irqStat_next;
   logic irqEn_reg, irqEn_next;
   logic [31:0] rdata_reg, rdata_next;
   logic addrPhase;
   logic [7:0] ad;
   logic [7:0] wb;

   assign addrPhase = hsel && htrans[1] && hready;
   assign ad = haddr[7:0];
   assign wb = hwdata[7:0];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // ==========================================
   // conversion engine
   typedef enum logic [1:0] {S_IDLE, S_CONV} conv_state_e;
   conv_state_e state_reg, state_next;
   logic [5:0] div_reg, div_next;
   logic [7:0] rcCnt_reg, rcCnt_next;
   logic [3:0] step_reg, step_next;
   logic [9:0] sar_reg, sar_next;
   logic [6:0] divLimit;
   logic tick;
   logic done;
   logic [2:0] clkSel;

   assign clkSel = ctrlB_reg[adc_ctrl_pkg::CLKSEL_LSB +: 3];

   always_comb begin
      case (clkSel)
         3'b000: divLimit = 7'd2;  // [RULE1]
         3'b100: divLimit = 7'd4;  // [RULE1]
         3'b001: divLimit = 7'd8;  // [RULE1]
         3'b101: divLimit = 7'd16;  // [RULE2]
         3'b010: divLimit = 7'd32;  // [RULE2]
         3'b110: divLimit = 7'd64;  // [RULE2]
         default: divLimit = 7'd0;
      endcase
   end

   // low bits 11 run from the rc counter instead of the divider [RULE3]
   always_comb begin
      div_next = div_reg;
      rcCnt_next = rcCnt_reg;
      tick = 1'b0;
      if (state_reg != S_CONV) begin
         div_next = '0;
         rcCnt_next = '0;
      end else if (clkSel[1:0] == 2'b11) begin
         if (rcCnt_reg == 8'(adc_ctrl_pkg::RC_CYCLES - 1)) begin
            rcCnt_next = '0;
            tick = 1'b1;
         end else begin
            rcCnt_next = rcCnt_reg + 8'd1;
         end
      end else begin
         if ({1'b0, div_reg} == divLimit - 7'd1) begin
            div_next = '0;
            tick = 1'b1;
         end else begin
            div_next = div_reg + 6'd1;
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      step_next = step_reg;
      sar_next = sar_reg;
      done = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (ctrlA_reg[adc_ctrl_pkg::GO_BIT] && ctrlA_reg[adc_ctrl_pkg::CONV_ON_BIT]) begin
               state_next = S_CONV;  // [RULE10]
               step_next = '0;
               sar_next = '0;
            end
         end
         S_CONV: begin
            if (!ctrlA_reg[adc_ctrl_pkg::CONV_ON_BIT]) begin
               state_next = S_IDLE;
            end else if (tick) begin
               if (step_reg != 4'd0) begin
                  sar_next = {sar_reg[8:0], sampleBit};
               end
               if (step_reg == 4'(adc_ctrl_pkg::CONV_PERIODS - 1)) begin
                  state_next = S_IDLE;
                  done = 1'b1;
               end else begin
                  step_next = step_reg + 4'd1;
               end
            end
         end
         default: state_next = S_IDLE;
      endcase
   end
   assign sampleStrobe = tick && (state_reg == S_CONV) && (step_reg != 4'd0);

   // ==========================================
   // registers and interrupt
   always_comb begin
      ctrlA_next = ctrlA_reg;
      ctrlB_next = ctrlB_reg;
      trig_next = trig_reg;
      resHi_next = resHi_reg;
      resLo_next = resLo_reg;
      vref_next = vref_reg;
      irqEn_next = irqEn_reg;
      irqStat_next = irqStat_reg;
      rdata_next = '0;
      wrPend_next = addrPhase && hwrite;
      wrAddr_next = ad;
      if (addrPhase && !hwrite) begin
         case (ad)
            adc_ctrl_pkg::OFF_CTRL_A: rdata_next = {24'h0000_00, ctrlA_reg};
            adc_ctrl_pkg::OFF_CTRL_B: rdata_next = {24'h0000_00, ctrlB_reg};
            adc_ctrl_pkg::OFF_TRIG: rdata_next = {24'h0000_00, trig_reg};
            adc_ctrl_pkg::OFF_RES_HI: rdata_next = {24'h0000_00, resHi_reg};
            adc_ctrl_pkg::OFF_RES_LO: rdata_next = {24'h0000_00, resLo_reg};
            adc_ctrl_pkg::OFF_VREF: rdata_next = {24'h0000_00, vref_reg};
            adc_ctrl_pkg::OFF_IRQ_STAT: rdata_next = {31'h0000_0000, irqStat_reg};
            adc_ctrl_pkg::OFF_IRQ_EN: rdata_next = {31'h0000_0000, irqEn_reg};
            default: rdata_next = '0;
         endcase
      end
      if (wrPend_reg) begin
         case (wrAddr_reg)
            adc_ctrl_pkg::OFF_CTRL_A: ctrlA_next = {1'b0, wb[6:0]};
            adc_ctrl_pkg::OFF_CTRL_B: ctrlB_next = {wb[7:4], 2'b00, wb[1:0]};
            adc_ctrl_pkg::OFF_TRIG: trig_next = {wb[7:4], 4'h0};
            adc_ctrl_pkg::OFF_RES_HI: resHi_next = wb;
            adc_ctrl_pkg::OFF_RES_LO: resLo_next = wb;
            adc_ctrl_pkg::OFF_VREF: vref_next = {wb[7], 1'b0, wb[5:4], 2'b00, wb[1:0]};
            adc_ctrl_pkg::OFF_IRQ_EN: irqEn_next = wb[0];
            adc_ctrl_pkg::OFF_IRQ_CLR: begin
               if (wb[0]) begin
                  irqStat_next = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (done) begin
         ctrlA_next[adc_ctrl_pkg::GO_BIT] = 1'b0;  // [RULE10]
         irqStat_next = 1'b1;  // [RULE10]
         if (!ctrlB_reg[adc_ctrl_pkg::FMT_BIT]) begin
            resHi_next = sar_next[9:2];  // [RULE8]
            resLo_next = {sar_next[1:0], 6'h00};  // [RULE9]
         end else begin
            resHi_next = {6'h00, sar_next[9:8]};
            resLo_next = sar_next[7:0];
         end
      end else if (state_reg == S_CONV && !ctrlA_reg[adc_ctrl_pkg::CONV_ON_BIT]) begin
         ctrlA_next[adc_ctrl_pkg::GO_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         div_reg <= '0;
         rcCnt_reg <= '0;
         step_reg <= '0;
         sar_reg <= '0;
         ctrlA_reg <= adc_ctrl_pkg::RST_BYTE;
         ctrlB_reg <= adc_ctrl_pkg::RST_BYTE;
         trig_reg <= adc_ctrl_pkg::RST_BYTE;
         resHi_reg <= adc_ctrl_pkg::RST_BYTE;
         resLo_reg <= adc_ctrl_pkg::RST_BYTE;
         vref_reg <= adc_ctrl_pkg::RST_BYTE;
         irqStat_reg <= 1'b0;
         irqEn_reg <= 1'b0;
         rdata_reg <= '0;
         wrPend_reg <= 1'b0;
         wrAddr_reg <= '0;
      end else begin
         state_reg <= state_next;
         div_reg <= div_next;
         rcCnt_reg <= rcCnt_next;
         step_reg <= step_next;
         sar_reg <= sar_next;
         ctrlA_reg <= ctrlA_next;
         ctrlB_reg <= ctrlB_next;
         trig_reg <= trig_next;
         resHi_reg <= resHi_next;
         resLo_reg <= resLo_next;
         vref_reg <= vref_next;
         irqStat_reg <= irqStat_next;
         irqEn_reg <= irqEn_next;
         rdata_reg <= rdata_next;
         wrPend_reg <= wrPend_next;
         wrAddr_reg <= wrAddr_next;
      end
   end

   // ==========================================
   // analogue side controls
   assign inputChannelSelect = ctrlA_reg[adc_ctrl_pkg::CHAN_LSB +: 5];
   assign tempSelected = inputChannelSelect == adc_ctrl_pkg::TEMP_CHANNEL;  // [RULE7]
   assign tempSenseEnable = vref_reg[adc_ctrl_pkg::TEMP_SENSE_ENABLE_BIT];  // [RULE11]
   assign tempRangeHigh = vref_reg[adc_ctrl_pkg::TEMP_SENSE_ENABLE_BIT] && vref_reg[adc_ctrl_pkg::TRNG_BIT];  // [RULE12]
   assign convIrq = irqStat_reg && irqEn_reg;

   // ==========================================
   // assertions
   property p_div8;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == S_CONV && clkSel == 3'b001 && tick) |-> ##8 (tick || state_reg != S_CONV || $changed(clkSel));
   endproperty
   a_div8: assert property (p_div8) else $error("divide by 8 period wrong"); // [RULE1]
   property p_div2;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == S_CONV && clkSel == 3'b000 && div_reg == 6'd1) |-> tick;
   endproperty
   a_div2: assert property (p_div2) else $error("divide by 2 tick missing"); // [RULE1]
   property p_div64;
      @(posedge clk_sys) disable iff (!rst_n)
      (clkSel == 3'b110 && tick) |-> div_reg == 6'd63;
   endproperty
   a_div64: assert property (p_div64) else $error("divide by 64 tick wrong"); // [RULE2]
   property p_rc;
      @(posedge clk_sys) disable iff (!rst_n)
      (clkSel[1:0] == 2'b11 && tick) |-> rcCnt_reg == 8'(adc_ctrl_pkg::RC_CYCLES - 1);
   endproperty
   a_rc: assert property (p_rc) else $error("rc period wrong"); // [RULE3]
   property p_done;
      @(posedge clk_sys) disable iff (!rst_n)
      done |=> (irqStat_reg && !ctrlA_reg[adc_ctrl_pkg::GO_BIT]);
   endproperty
   a_done: assert property (p_done) else $error("done did not flag"); // [RULE10]
   property p_left;
      @(posedge clk_sys) disable iff (!rst_n)
      (done && !ctrlB_reg[adc_ctrl_pkg::FMT_BIT]) |=> resHi_reg == $past(sar_next[9:2]);
   endproperty
   a_left: assert property (p_left) else $error("high result wrong"); // [RULE8]
   property p_low;
      @(posedge clk_sys) disable iff (!rst_n)
      (done && !ctrlB_reg[adc_ctrl_pkg::FMT_BIT]) |=> resLo_reg[5:0] == 6'h00;
   endproperty
   a_low: assert property (p_low) else $error("low result wrong"); // [RULE9]
   property p_temp;
      @(posedge clk_sys) disable iff (!rst_n)
      !tempSenseEnable |-> !tempRangeHigh;
   endproperty
   a_temp: assert property (p_temp) else $error("temp active while off"); // [RULE11]
   property p_rng;
      @(posedge clk_sys) disable iff (!rst_n)
      tempSenseEnable |-> tempRangeHigh == vref_reg[adc_ctrl_pkg::TRNG_BIT];
   endproperty
   a_rng: assert property (p_rng) else $error("range wrong"); // [RULE12]
   property p_chan;
      @(posedge clk_sys) disable iff (!rst_n)
      tempSelected |-> inputChannelSelect == 5'h1D;
   endproperty
   a_chan: assert property (p_chan) else $error("temp channel wrong"); // [RULE7]
   c_conv: cover property (@(posedge clk_sys) disable iff (!rst_n) done);
   c_rc: cover property (@(posedge clk_sys) disable iff (!rst_n) done && clkSel[1:0] == 2'b11);
   c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) convIrq);
endmodule

// File: adc_clock_result_control_tb_top.sv
module adc_clock_result_control_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TEMP_WAIT = 200 * adc_ctrl_pkg::CLK_MHZ;
   logic clk_sys, rst_n, hwrite, hsel, hready, hreadyout, hresp, sampleBit, convIrq;
   logic tempSelected, tempSenseEnable, tempRangeHigh, sampleStrobe;
   logic [31:0] haddr, hwdata, hrdata, rd, rdS;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] inputChannelSelect;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int lastS, gMin, gMax, sCnt;
   assign hready = hreadyout;
   adc_clock_result_control dut_u (.clk_sys, .rst_n, .haddr, .htrans, .hwrite, .hsize, .hsel,
      .hready, .hwdata, .hrdata, .hreadyout, .hresp, .sampleBit, .inputChannelSelect,
      .tempSelected, .tempSenseEnable, .tempRangeHigh, .sampleStrobe, .convIrq);
   adc_analog_model model_u (.clk_sys, .rst_n, .inputChannelSelect, .tempSelected,
      .tempSenseEnable, .tempRangeHigh, .sampleStrobe, .sampleBit);
   // ==========================================
   // clock and strobe spacing monitor
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      cyc = cyc + 1;
      if (sampleStrobe === 1'b1) begin
         if (sCnt > 0 && cyc - lastS < gMin) gMin = cyc - lastS;
         if (sCnt > 0 && cyc - lastS > gMax) gMax = cyc - lastS;
         lastS = cyc;
         sCnt = sCnt + 1;
      end
   end
   // ==========================================
   // report, compare and bus tasks
   task end_sim;
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wait_rdy;
      int n;
      n = 0;
      @(posedge clk_sys);
      while (hready !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      rdS = hrdata;
      if (n >= 100) begin
         err_count++;
         end_sim();
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, wd};
      wait_rdy();
      rd = rdS;
   endtask
   function automatic int div_of(input logic [2:0] c);
      case (c)
         3'b000: return 2;
         3'b100: return 4;
         3'b001: return 8;
         3'b101: return 16;
         3'b010: return 32;
         3'b110: return 64;
         default: return adc_ctrl_pkg::RC_CYCLES;
      endcase
   endfunction
   task convert(input logic [4:0] ch, input logic [2:0] cs, input logic [9:0] ev);
      int n;
      bus(1'b1, adc_ctrl_pkg::OFF_CTRL_B, {1'b0, cs, 4'h0});
      sCnt = 0;
      gMin = 100000;
      gMax = 0;
      bus(1'b1, adc_ctrl_pkg::OFF_CTRL_A, {1'b0, ch, 2'b11});
      n = 0;
      rd = 32'h0000_0002;
      while (rd[1] !== 1'b0 && n < 3000) begin
         bus(1'b0, adc_ctrl_pkg::OFF_CTRL_A, 8'h00);
         n++;
      end
      if (n >= 3000) begin
         err_count++;
         end_sim();
      end
      chk(rd, {25'h000_0000, ch, 2'b01});
      chk(sCnt, 10);
      chk(gMin, div_of(cs));
      chk(gMax, div_of(cs));
      bus(1'b0, adc_ctrl_pkg::OFF_RES_HI, 8'h00);
      chk(rd, {24'h00_0000, ev[9:2]});
      bus(1'b0, adc_ctrl_pkg::OFF_RES_LO, 8'h00);
      chk({30'h0000_0000, rd[7:6]}, {30'h0000_0000, ev[1:0]});
   endtask
   // ==========================================
   // scenarios
   task t_reset;
      for (int a = 0; a <= 36; a += 4) begin
         bus(1'b0, 8'(a), 8'h00);
         chk(rd, 32'h0000_0000);
      end
      bus(1'b1, 8'h24, 8'hff);
      bus(1'b0, 8'h24, 8'h00);
      chk(rd, 32'h0000_0000);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask
   task t_clock;
      for (int c = 0; c < 8; c++) begin
         convert(5'(c + 3), 3'(c), {5'(c + 3), ~5'(c + 3)});
      end
   endtask
   task t_irq;
      bus(1'b0, adc_ctrl_pkg::OFF_IRQ_STAT, 8'h00);
      chk(rd, 32'h0000_0001);
      chk({31'h0000_0000, convIrq}, 32'h0000_0000);
      bus(1'b1, adc_ctrl_pkg::OFF_IRQ_EN, 8'h01);
      bus(1'b0, adc_ctrl_pkg::OFF_IRQ_CLR, 8'h00);
      chk({31'h0000_0000, convIrq}, 32'h0000_0001);
      bus(1'b1, adc_ctrl_pkg::OFF_IRQ_CLR, 8'h01);
      bus(1'b0, adc_ctrl_pkg::OFF_IRQ_STAT, 8'h00);
      chk(rd, 32'h0000_0000);
      chk({31'h0000_0000, convIrq}, 32'h0000_0000);
      convert(5'h02, 3'b000, {5'h02, 5'h1d});
      chk({31'h0000_0000, convIrq}, 32'h0000_0001);
      bus(1'b1, adc_ctrl_pkg::OFF_IRQ_CLR, 8'h01);
   endtask
   task t_format;
      int n;
      bus(1'b1, adc_ctrl_pkg::OFF_CTRL_B, 8'h80);
      bus(1'b1, adc_ctrl_pkg::OFF_CTRL_A, {1'b0, 5'h15, 2'b11});
      n = 0;
      rd = 32'h0000_0002;
      while (rd[1] !== 1'b0 && n < 3000) begin
         bus(1'b0, adc_ctrl_pkg::OFF_CTRL_A, 8'h00);
         n++;
      end
      if (n >= 3000) begin
         err_count++;
         end_sim();
      end
      bus(1'b0, adc_ctrl_pkg::OFF_RES_HI, 8'h00);
      chk(rd, 32'h0000_0002);
      bus(1'b0, adc_ctrl_pkg::OFF_RES_LO, 8'h00);
      chk(rd, 32'h0000_00aa);
   endtask
   task t_temp;
      bus(1'b1, adc_ctrl_pkg::OFF_VREF, 8'h10);
      bus(1'b1, adc_ctrl_pkg::OFF_CTRL_A, {1'b0, adc_ctrl_pkg::TEMP_CHANNEL, 2'b00});
      bus(1'b0, adc_ctrl_pkg::OFF_VREF, 8'h00);
      chk({27'h000_0000, inputChannelSelect}, 32'h0000_001d);
      chk({29'h0000_0000, tempSelected, tempSenseEnable, tempRangeHigh}, 32'h4);
      bus(1'b1, adc_ctrl_pkg::OFF_VREF, 8'h30);
      bus(1'b0, adc_ctrl_pkg::OFF_VREF, 8'h00);
      chk({30'h0000_0000, tempSenseEnable, tempRangeHigh}, 32'h3);
      repeat (TEMP_WAIT) @(posedge clk_sys);
      convert(adc_ctrl_pkg::TEMP_CHANNEL, 3'b011, 10'h2c5);
      bus(1'b1, adc_ctrl_pkg::OFF_VREF, 8'h20);
      bus(1'b0, adc_ctrl_pkg::OFF_VREF, 8'h00);
      chk({30'h0000_0000, tempSenseEnable, tempRangeHigh}, 32'h2);
      repeat (TEMP_WAIT) @(posedge clk_sys);
      convert(adc_ctrl_pkg::TEMP_CHANNEL, 3'b111, 10'h1a3);
   endtask
   // ==========================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      hsel = 1'b1;
      hsize = 3'b010;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_clock();
      t_irq();
      t_format();
      t_temp();
      end_sim();
   end
endmodule

// File: adc_ctrl_pkg.sv
// Notes on behaviour
// RULE1 - codes 000,100,001 divide by 2,4,8
// RULE2 - codes 101,010,110 divide by 16,32,64
// RULE3 - low bits 11 select dedicated RC clock
// RULE4 - software uses RC clock in sleep
// RULE5 - software waits 200 us after temp select
// RULE6 - software leaves 200 us between temp conversions
// RULE7 - one channel reserved for temperature indicator
// RULE8 - high result holds bits nine to two
// RULE9 - low result bits 7-6 hold bits one, zero
// RULE10 - go starts conversion, done clears, loads, flags
// RULE11 - temp indicator off unless enable set
// RULE12 - range bit picks high or low range
package adc_ctrl_pkg;
   // ==========================================
   // register byte addresses
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_TRIG = 8'h08;
   localparam logic [7:0] OFF_RES_HI = 8'h0C;
   localparam logic [7:0] OFF_RES_LO = 8'h10;
   localparam logic [7:0] OFF_VREF = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_EN = 8'h1C;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
   // ==========================================
   // field positions
   localparam int CONV_ON_BIT = 0;
   localparam int GO_BIT = 1;
   localparam int CHAN_LSB = 2;
   localparam int CLKSEL_LSB = 4;
   localparam int FMT_BIT = 7;
   localparam int TRIG_LSB = 4;
   localparam int PREF_LSB = 0;
   localparam int TRNG_BIT = 4;
   localparam int TEMP_SENSE_ENABLE_BIT = 5;
   localparam int FVREN_BIT = 7;
   // ==========================================
   // reset values and constants
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] TEMP_CHANNEL = 5'h1D;
   localparam int CONV_BITS = 10;
   localparam int CONV_PERIODS = 11;
   localparam int CLK_MHZ = 40;
   localparam int RC_PERIOD_NS = 4000;
   localparam int RC_CYCLES = RC_PERIOD_NS * CLK_MHZ / 1000;
endpackage
